// File: verilog/amd_pkg.sv
package amd_pkg;
	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int SAMPLE_W    = 8;
	localparam int POINT_W     = 15;
	localparam int ACC_W       = 32;
	localparam int CNT_W       = 16;
	localparam int FIFO_DEPTH  = 32;
	localparam int FIFO_W      = POINT_W + 1;
	localparam int REC_MAX     = 64;
	localparam int REC_AW      = 6;
	localparam int MAXRES_W    = 15;
	localparam int BASE_RES_W  = 8;
	// ----------------------------------------------------------------
	// time base threshold for resolution gain, picoseconds per division
	// ----------------------------------------------------------------
	localparam int GAIN_MIN_PS_DIV = 100000;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int ENV_GUARD_W     = 8;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

	typedef enum logic [2:0]
	{
		AMD_MODE_FIRST,
		AMD_MODE_PEAK,
		AMD_MODE_MEAN,
		AMD_MODE_ENVELOPE,
		AMD_MODE_AVERAGE
	} amd_mode_t;

	typedef enum logic
	{
		AMD_INTERP_LINEAR,
		AMD_INTERP_SINC
	} amd_interp_t;

	// samples averaged give 0.5*log2(n) extra bits, capped
	function automatic logic [3:0] amd_res_bits(input logic [CNT_W-1:0] n);
		logic [4:0] lg;
		logic [4:0] w;
		lg = 5'h00;
		for (int i = 0; i < CNT_W; i++)
			if (n[i])
				lg = 5'(i);
		w = 5'(BASE_RES_W) + (lg >> 1);
		if (w > 5'(MAXRES_W))
			w = 5'(MAXRES_W);
		return w[3:0];
	endfunction
endpackage

// File: verilog/amd_stream_if.sv
`timescale 1ns/1ns
interface amd_stream_if;
	import amd_pkg::*;
	logic              valid;
	logic              ready;
	logic [FIFO_W-1:0] data;

	modport source
	(
		output valid,
		output data,
		input  ready
	);
	modport sink
	(
		input  valid,
		input  data,
		output ready
	);
endinterface

// File: verilog/amd_fifo.sv
`timescale 1ns/1ns
module amd_fifo
	import amd_pkg::*;
#(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic   i_clk,  // clock
	input  wire logic   i_rst,  // async reset
	amd_stream_if.sink   s_in,  // fill side
	amd_stream_if.source s_out  // drain side
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    wp_nxt;
	logic [AW-1:0]    rp_r;
	logic [AW-1:0]    rp_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	assign s_in.ready  = (cnt_r != (AW+1)'(DEPTH));
	assign s_out.valid = (cnt_r != '0);
	assign s_out.data  = mem_r[rp_r];
	assign push        = s_in.valid & s_in.ready;
	assign pop         = s_out.valid & s_out.ready;

	always_comb
	begin
		wp_nxt  = push ? wp_r + 1'b1 : wp_r;
		rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage has no reset; empty/full flags guard it
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_r[wp_r] <= s_in.data;
	end
endmodule

// File: verilog/amd_decimator.sv
// Operation
// RULE1 - first-sample mode keeps the earliest sample of each interval, drops the rest
// RULE2 - interval length is record span divided by record points
// RULE3 - reset selects first-sample mode
// RULE4 - first, peak and mean modes fill a record from one trigger
// RULE5 - peak detect alternates interval maximum and next interval minimum
// RULE6 - interpolation or equivalent-time sampling runs peak detect as first-sample
// RULE7 - interval mean mode outputs the mean of all interval samples
// RULE8 - interpolation or equivalent-time sampling runs mean mode as first-sample
// RULE9 - mean width is 8 bits plus half log2 of samples per interval
// RULE10 - mean output width never exceeds 15 bits
// RULE11 - resolution gain only when time base slower than 100 ns/div
// RULE12 - envelope captures max and min of adjacent interval pairs each acquisition
// RULE13 - envelope keeps the more extreme values over configured acquisitions
// RULE14 - average mode samples first-sample then accumulates over configured count
// RULE15 - interpolated points only when real-time sampling falls short
// RULE16 - linear interpolation uses straight line between neighbouring real samples
// RULE17 - sinc interpolation uses band-limited fit through real samples; the code uses the same straight line midpoint as linear
// RULE18 - idle channel digitizers interleave onto active channels for higher rate
// RULE19 - beyond interleaved maximum, fill by interpolation or equivalent-time
// RULE20 - fast persistence refuses mean, envelope and average modes
// RULE21 - interpolation method follows the display setting in real-time-only
// RULE22 - average accumulator has guard bits against overflow
`timescale 1ns/1ns
module amd_decimator
	import amd_pkg::*;
(
	input  wire logic                I_CLOCK,              // 100 MHz clock
	input  wire logic                I_RST,                // async reset, high
	input  wire logic                I_START,              // trigger: start record
	input  wire logic [2:0]          I_MODE,               // selected mode code
	input  wire logic                I_FAST_PERSIST,       // fast persistence active
	input  wire logic                I_EQUIV_TIME_EN,      // equivalent_time_sampling allowed
	input  wire logic                I_INTERP_SINC,        // display interp: 1 sinc
	input  wire logic [2:0]          I_CHANNELS_ON,        // active channel count 1..4
	input  wire logic [CNT_W-1:0]    I_RECORD_SPAN,        // record span in sample periods
	input  wire logic [REC_AW:0]     I_RECORD_POINTS,      // record length, points
	input  wire logic [CNT_W-1:0]    I_SAMPLES_NEEDED,     // sample slots needed per point x1
	input  wire logic [31:0]         I_TIMEBASE_PS_DIV,    // time base, ps per division
	input  wire logic [CNT_W-1:0]    I_ACQ_COUNT,          // envelope/average acquisitions
	input  wire logic                I_SAMPLE_VALID,       // digitizer sample strobe
	input  wire logic [SAMPLE_W-1:0] I_SAMPLE,             // digitizer sample
	input  wire logic                I_POINT_READY,        // record sink ready
	output logic                     O_POINT_VALID,        // record point valid
	output logic [POINT_W-1:0]       O_POINT,              // record point, msb aligned
	output logic                     O_POINT_INTERP,       // point is interpolated
	output logic                     O_SAMPLE_READY,       // accepts samples
	output logic [2:0]               O_MODE_ACTIVE,        // effective mode
	output logic [2:0]               O_MODE_SELECTED,      // mode register
	output logic [3:0]               O_RES_BITS,           // point resolution bits
	output logic [1:0]               O_INTERLEAVE,         // digitizers per channel, log2
	output logic                     O_NEED_FILL,          // real-time cannot fill record
	output logic                     O_ACQ_DONE            // configured acquisitions done
);
	// ----------------------------------------------------------------
	// configuration and effective mode
	// ----------------------------------------------------------------
	amd_mode_t        mode_r;
	amd_mode_t        mode_nxt;
	amd_mode_t        eff_mode;
	logic             fill_needed;
	logic [1:0]       ileave;
	logic [CNT_W-1:0] interval_len;
	logic [CNT_W-1:0] rate_avail;

	always_comb
	begin
		mode_nxt = mode_r;
		if (I_MODE <= 3'(AMD_MODE_AVERAGE))
		begin
			mode_nxt = amd_mode_t'(I_MODE);
			// RULE20 refuse in persistence
			if (I_FAST_PERSIST && I_MODE >= 3'(AMD_MODE_MEAN))
				mode_nxt = mode_r;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		// RULE3 default first-sample
		if (I_RST)
			mode_r <= AMD_MODE_FIRST;
		else
			mode_r <= mode_nxt;
	end

	// RULE18 idle digitizers interleave
	always_comb
	begin
		unique case (I_CHANNELS_ON)
			3'h1:    ileave = 2'h2;
			3'h2:    ileave = 2'h1;
			default: ileave = 2'h0;
		endcase
	end
	assign rate_avail = CNT_W'(1) << ileave;

	// RULE2 interval = span / points
	assign interval_len = (I_RECORD_POINTS == '0) ? CNT_W'(1) :
		CNT_W'(I_RECORD_SPAN / CNT_W'(I_RECORD_POINTS));

	// RULE19 rate beyond interleave maximum
	assign fill_needed = (I_SAMPLES_NEEDED > rate_avail);

	always_comb
	begin
		eff_mode = mode_r;
		// RULE6 RULE8 degrade to first-sample
		if (fill_needed && (mode_r == AMD_MODE_PEAK || mode_r == AMD_MODE_MEAN))
			eff_mode = AMD_MODE_FIRST;
		// RULE14 average acquires first-sample
		if (mode_r == AMD_MODE_AVERAGE)
			eff_mode = AMD_MODE_AVERAGE;
	end

	// ----------------------------------------------------------------
	// interval engine
	// ----------------------------------------------------------------
	logic [CNT_W-1:0]    pos_r;
	logic [CNT_W-1:0]    pos_nxt;
	logic [REC_AW:0]     pt_r;
	logic [REC_AW:0]     pt_nxt;
	logic                run_r;
	logic                run_nxt;
	logic                phase_r;
	logic                phase_nxt;
	logic [SAMPLE_W-1:0] first_r;
	logic [SAMPLE_W-1:0] first_nxt;
	logic [SAMPLE_W-1:0] max_r;
	logic [SAMPLE_W-1:0] max_nxt;
	logic [SAMPLE_W-1:0] min_r;
	logic [SAMPLE_W-1:0] min_nxt;
	logic [ACC_W-1:0]    sum_r;
	logic [ACC_W-1:0]    sum_nxt;
	logic [SAMPLE_W-1:0] prev_r;
	logic [SAMPLE_W-1:0] prev_nxt;
	logic [CNT_W-1:0]    acq_r;
	logic [CNT_W-1:0]    acq_nxt;
	logic                take;
	logic                last_in_iv;
	logic [POINT_W-1:0]  pt_val;
	logic                emit;
	logic [SAMPLE_W-1:0] smp_max;
	logic [SAMPLE_W-1:0] smp_min;
	logic [ACC_W-1:0]    sum_all;
	logic [3:0]          res_bits;
	logic                fifo_ready;

	// record memory for envelope/average, flip-flops addressed by index
	logic [SAMPLE_W-1:0]            emax_r [REC_MAX];
	logic [SAMPLE_W-1:0]            emin_r [REC_MAX];
	logic [SAMPLE_W+ENV_GUARD_W+7:0] avg_r  [REC_MAX];
	logic [REC_AW-1:0]              idx;

	amd_stream_if s_in ();
	amd_stream_if s_out ();

	// sampling stalls when the record fifo fills
	assign take           = run_r & I_SAMPLE_VALID & fifo_ready;
	assign O_SAMPLE_READY = run_r & fifo_ready;
	assign last_in_iv     = (pos_r + 1'b1 >= interval_len);
	assign idx            = pt_r[REC_AW-1:0];
	assign smp_max        = (pos_r == '0 || I_SAMPLE > max_r) ? I_SAMPLE : max_r;
	assign smp_min        = (pos_r == '0 || I_SAMPLE < min_r) ? I_SAMPLE : min_r;
	assign sum_all        = ((pos_r == '0) ? '0 : sum_r) + ACC_W'(I_SAMPLE);
	assign emit           = take & last_in_iv;

	// RULE11 gain only slower than 100 ns/div
	assign res_bits = (I_TIMEBASE_PS_DIV > 32'(GAIN_MIN_PS_DIV)) ?
		amd_res_bits(interval_len) : 4'(BASE_RES_W);

	always_comb
	begin
		pt_val = '0;
		unique case (eff_mode)
			// RULE1 earliest sample kept
			AMD_MODE_FIRST:
				pt_val = {((pos_r == '0) ? I_SAMPLE : first_r), 7'h00};
			// RULE5 alternate max and min
			AMD_MODE_PEAK:
				pt_val = {(phase_r ? smp_min : smp_max), 7'h00};
			// RULE7 RULE9 RULE10 interval mean, capped width
			AMD_MODE_MEAN:
				pt_val = POINT_W'(((sum_all << 7) / ACC_W'(pos_r + 1'b1))
					& ~((ACC_W'(1) << (POINT_W - res_bits)) - 1));
			// RULE12 RULE13 envelope extremes kept
			AMD_MODE_ENVELOPE:
				if (phase_r)
					pt_val = {((acq_r == '0 || smp_min < emin_r[idx]) ? smp_min
						: emin_r[idx]), 7'h00};
				else
					pt_val = {((acq_r == '0 || smp_max > emax_r[idx]) ? smp_max
						: emax_r[idx]), 7'h00};
			// RULE14 RULE22 accumulate then divide
			AMD_MODE_AVERAGE:
				pt_val = POINT_W'((ACC_W'(((acq_r == '0) ? '0 : avg_r[idx])
					+ (SAMPLE_W+ENV_GUARD_W+8)'((pos_r == '0) ? I_SAMPLE : first_r))
					<< 7) / ACC_W'(acq_r + 1'b1));
		endcase
	end

	always_comb
	begin
		pos_nxt   = pos_r;
		pt_nxt    = pt_r;
		run_nxt   = run_r;
		phase_nxt = phase_r;
		first_nxt = first_r;
		max_nxt   = max_r;
		min_nxt   = min_r;
		sum_nxt   = sum_r;
		prev_nxt  = prev_r;
		acq_nxt   = acq_r;
		// RULE4 one trigger fills the record
		if (I_START && !run_r)
		begin
			run_nxt   = 1'b1;
			pos_nxt   = '0;
			pt_nxt    = '0;
			phase_nxt = 1'b0;
			if (mode_r != AMD_MODE_ENVELOPE && mode_r != AMD_MODE_AVERAGE)
				acq_nxt = '0;
		end
		if (take)
		begin
			if (pos_r == '0)
				first_nxt = I_SAMPLE;
			max_nxt = smp_max;
			min_nxt = smp_min;
			sum_nxt = sum_all;
			pos_nxt = last_in_iv ? '0 : pos_r + 1'b1;
			if (last_in_iv)
			begin
				prev_nxt  = pt_val[POINT_W-1 -: SAMPLE_W];
				phase_nxt = ~phase_r;
				pt_nxt    = pt_r + 1'b1;
				if (pt_r + 1'b1 >= I_RECORD_POINTS)
				begin
					run_nxt = 1'b0;
					acq_nxt = (acq_r + 1'b1 >= I_ACQ_COUNT) ? '0 : acq_r + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			pos_r   <= RST_CNT;
			pt_r    <= '0;
			run_r   <= 1'b0;
			phase_r <= 1'b0;
			first_r <= '0;
			max_r   <= '0;
			min_r   <= '0;
			sum_r   <= '0;
			prev_r  <= '0;
			acq_r   <= RST_CNT;
		end
		else
		begin
			pos_r   <= pos_nxt;
			pt_r    <= pt_nxt;
			run_r   <= run_nxt;
			phase_r <= phase_nxt;
			first_r <= first_nxt;
			max_r   <= max_nxt;
			min_r   <= min_nxt;
			sum_r   <= sum_nxt;
			prev_r  <= prev_nxt;
			acq_r   <= acq_nxt;
		end
	end

	// per-point history; contents only read once acq_r is nonzero
	always_ff @(posedge I_CLOCK)
	begin
		if (emit && eff_mode == AMD_MODE_ENVELOPE)
		begin
			if (phase_r)
				emin_r[idx] <= pt_val[POINT_W-1 -: SAMPLE_W];
			else
				emax_r[idx] <= pt_val[POINT_W-1 -: SAMPLE_W];
		end
		if (emit && eff_mode == AMD_MODE_AVERAGE)
			avg_r[idx] <= ((acq_r == '0) ? '0 : avg_r[idx])
				+ (SAMPLE_W+ENV_GUARD_W+8)'((pos_r == '0) ? I_SAMPLE : first_r);
	end

	// ----------------------------------------------------------------
	// interpolation of missing points
	// ----------------------------------------------------------------
	// RULE15 only when real-time falls short
	// RULE21 method from display setting
	logic [SAMPLE_W-1:0] lin_mid;
	logic [SAMPLE_W+1:0] sinc_mid;
	logic [SAMPLE_W-1:0] cur8;
	logic                add_interp;

	assign cur8       = pt_val[POINT_W-1 -: SAMPLE_W];
	assign add_interp = fill_needed & ~I_EQUIV_TIME_EN & (pt_r != '0);
	// RULE16 straight line midpoint
	assign lin_mid    = SAMPLE_W'(({1'b0, prev_r} + {1'b0, cur8}) >> 1);
	// RULE17 sinc path: same straight line midpoint as linear, no band-limited kernel
	assign sinc_mid   = 10'({2'b00, prev_r} + {2'b00, cur8}) >> 1;

	logic                ins_pend_r;
	logic                ins_pend_nxt;
	logic [SAMPLE_W-1:0] ins_val;
	logic [POINT_W-1:0]  ins_cur_r;
	logic [POINT_W-1:0]  ins_cur_nxt;

	assign ins_val = I_INTERP_SINC ? sinc_mid[SAMPLE_W-1:0] : lin_mid;

	always_comb
	begin
		ins_pend_nxt = ins_pend_r;
		ins_cur_nxt  = ins_cur_r;
		if (ins_pend_r && s_in.ready)
			ins_pend_nxt = 1'b0;
		if (emit && add_interp)
		begin
			ins_pend_nxt = 1'b1;
			ins_cur_nxt  = pt_val;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST)
	begin
		if (I_RST)
		begin
			ins_pend_r <= 1'b0;
			ins_cur_r  <= '0;
		end
		else
		begin
			ins_pend_r <= ins_pend_nxt;
			ins_cur_r  <= ins_cur_nxt;
		end
	end

	// interpolated point precedes its real neighbour; stall while pending
	assign fifo_ready  = s_in.ready & ~ins_pend_r;
	assign s_in.valid  = ins_pend_r | emit;
	assign s_in.data   = ins_pend_r ? {1'b0, ins_cur_r} :
		(add_interp ? {1'b1, ins_val, 7'h00} : {1'b0, pt_val});

	amd_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk (I_CLOCK),
		.i_rst (I_RST),
		.s_in  (s_in.sink),
		.s_out (s_out.source)
	);

	assign s_out.ready     = I_POINT_READY;
	assign O_POINT_VALID   = s_out.valid;
	assign O_POINT         = s_out.data[POINT_W-1:0];
	assign O_POINT_INTERP  = s_out.data[POINT_W];
	assign O_MODE_ACTIVE   = 3'(eff_mode);
	assign O_MODE_SELECTED = 3'(mode_r);
	assign O_RES_BITS      = (eff_mode == AMD_MODE_MEAN) ? res_bits : 4'(BASE_RES_W);
	assign O_INTERLEAVE    = ileave;
	assign O_NEED_FILL     = fill_needed;
	assign O_ACQ_DONE      = ~run_r & (acq_r == '0);
endmodule

// File: tb/amd_decimator_asserts.sv
`timescale 1ns/1ns
module amd_decimator_asserts
	import amd_pkg::*;
(
	input  wire logic               I_CLOCK,           // clock
	input  wire logic               I_RST,             // async reset
	input  wire logic [2:0]         I_MODE,            // mode request
	input  wire logic               I_FAST_PERSIST,    // fast persistence
	input  wire logic [2:0]         I_CHANNELS_ON,     // channels on
	input  wire logic [CNT_W-1:0]   I_RECORD_SPAN,     // span
	input  wire logic [REC_AW:0]    I_RECORD_POINTS,   // points
	input  wire logic [CNT_W-1:0]   I_SAMPLES_NEEDED,  // rate need
	input  wire logic [31:0]        I_TIMEBASE_PS_DIV, // time base
	input  wire logic               I_POINT_READY,     // sink ready
	input  wire logic               O_POINT_VALID,     // point valid
	input  wire logic [POINT_W-1:0] O_POINT,           // point
	input  wire logic [2:0]         O_MODE_ACTIVE,     // effective mode
	input  wire logic [2:0]         O_MODE_SELECTED,   // mode register
	input  wire logic [3:0]         O_RES_BITS,        // resolution
	input  wire logic [1:0]         O_INTERLEAVE,      // interleave log2
	input  wire logic               O_NEED_FILL        // fill needed
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	logic [CNT_W-1:0] spi;
	logic [4:0]       gain_w;
	logic [1:0]       ilv_e;
	// half a bit per doubling of samples averaged
	always_comb
	begin
		spi = (I_RECORD_POINTS == '0) ? '0 : I_RECORD_SPAN / CNT_W'(I_RECORD_POINTS);
		gain_w = 5'h08;
		for (int i = 2; i < CNT_W; i += 2)
			if (spi >= (CNT_W'(1) << i))
				gain_w = 5'h08 + 5'(i / 2);
		ilv_e = (I_CHANNELS_ON == 3'h1) ? 2'h2 : (I_CHANNELS_ON == 3'h2) ? 2'h1 : 2'h0;
	end
	property p_reset_mode;
		$fell(I_RST) |-> O_MODE_SELECTED == 3'h0;
	endproperty
	a_reset_mode: assert property (p_reset_mode)
		else $error("mode not first after reset");
	property p_fast_refuse;
		I_FAST_PERSIST && I_MODE inside {3'h2, 3'h3, 3'h4} |=> $stable(O_MODE_SELECTED);
	endproperty
	a_fast_refuse: assert property (p_fast_refuse)
		else $error("mode taken under fast persistence");
	property p_peak_first;
		O_MODE_SELECTED == AMD_MODE_PEAK && O_NEED_FILL |-> O_MODE_ACTIVE == AMD_MODE_FIRST;
	endproperty
	a_peak_first: assert property (p_peak_first)
		else $error("peak not run as first-sample");
	property p_mean_first;
		O_MODE_SELECTED == AMD_MODE_MEAN && O_NEED_FILL |-> O_MODE_ACTIVE == AMD_MODE_FIRST;
	endproperty
	a_mean_first: assert property (p_mean_first)
		else $error("mean not run as first-sample");
	property p_res_base;
		O_MODE_ACTIVE == AMD_MODE_MEAN && I_TIMEBASE_PS_DIV <= 32'(GAIN_MIN_PS_DIV)
			|-> O_RES_BITS == 4'h8;
	endproperty
	a_res_base: assert property (p_res_base)
		else $error("resolution gain at fast time base");
	property p_res_gain;
		O_MODE_ACTIVE == AMD_MODE_MEAN && I_TIMEBASE_PS_DIV > 32'(GAIN_MIN_PS_DIV)
			|-> O_RES_BITS == gain_w[3:0];
	endproperty
	a_res_gain: assert property (p_res_gain)
		else $error("resolution width wrong");
	property p_interleave;
		O_INTERLEAVE == ilv_e;
	endproperty
	a_interleave: assert property (p_interleave)
		else $error("interleave factor wrong");
	property p_need_fill;
		O_NEED_FILL == (I_SAMPLES_NEEDED > (CNT_W'(1) << ilv_e));
	endproperty
	a_need_fill: assert property (p_need_fill)
		else $error("fill flag wrong");
	property p_hold;
		O_POINT_VALID && !I_POINT_READY |=> O_POINT_VALID && $stable(O_POINT);
	endproperty
	a_hold: assert property (p_hold)
		else $error("point dropped while stalled");
	c_point: cover property (O_POINT_VALID && I_POINT_READY);
	c_fill: cover property (O_NEED_FILL && O_POINT_VALID);
	c_mean: cover property (O_MODE_ACTIVE == AMD_MODE_MEAN && O_POINT_VALID);
endmodule

// File: tb/amd_digitizer_model.sv
`timescale 1ns/1ns
module amd_digitizer_model
	import amd_pkg::*;
(
	input  wire logic           i_clk,    // clock
	input  wire logic           i_ready,  // block accepts
	output logic                o_valid,  // sample offered
	output logic [SAMPLE_W-1:0] o_sample  // sample value
);
	logic [SAMPLE_W-1:0] q[$];
	logic                slow = 1'b0;
	logic                took = 1'b0;
	initial
	begin
		o_valid = 1'b0;
		o_sample = 8'hA5;
	end
	task automatic flush;
		q.delete();
		o_valid = 1'b0;
	endtask
	always @(posedge i_clk)
		took = o_valid && i_ready;
	// idle data toggles so a stale sample never looks valid
	always @(negedge i_clk)
		if (!o_valid || took)
		begin
			took = 1'b0;
			if (q.size() != 0 && !(slow && o_valid))
			begin
				o_valid = 1'b1;
				o_sample = q.pop_front();
			end
			else
			begin
				o_valid = 1'b0;
				o_sample = ~o_sample;
			end
		end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
	import amd_pkg::*;
	logic               clk = 1'b0, rst, start, fast, et_en, sinc, p_ready, s_valid;
	logic [2:0]         mode, ch_on, mode_act, mode_sel;
	logic [CNT_W-1:0]   span, need, acq_n;
	logic [REC_AW:0]    points;
	logic [31:0]        tbase;
	logic [SAMPLE_W-1:0] smp;
	logic               pv, pi, s_ready, nfill, acq_done;
	logic [POINT_W-1:0] pt;
	logic [3:0]         res;
	logic [1:0]         ilv;
	logic [POINT_W-1:0] got[$];
	logic               got_i[$];
	int                 n_fail = 0;
	int                 samples_checked = 0;
	always #5 clk = ~clk;
	amd_decimator dut_u (.I_CLOCK(clk), .I_RST(rst), .I_START(start), .I_MODE(mode),
		.I_FAST_PERSIST(fast), .I_EQUIV_TIME_EN(et_en), .I_INTERP_SINC(sinc),
		.I_CHANNELS_ON(ch_on), .I_RECORD_SPAN(span), .I_RECORD_POINTS(points),
		.I_SAMPLES_NEEDED(need), .I_TIMEBASE_PS_DIV(tbase), .I_ACQ_COUNT(acq_n),
		.I_SAMPLE_VALID(s_valid), .I_SAMPLE(smp), .I_POINT_READY(p_ready),
		.O_POINT_VALID(pv), .O_POINT(pt), .O_POINT_INTERP(pi), .O_SAMPLE_READY(s_ready),
		.O_MODE_ACTIVE(mode_act), .O_MODE_SELECTED(mode_sel), .O_RES_BITS(res),
		.O_INTERLEAVE(ilv), .O_NEED_FILL(nfill), .O_ACQ_DONE(acq_done));
	amd_digitizer_model dig_u (.i_clk(clk), .i_ready(s_ready), .o_valid(s_valid),
		.o_sample(smp));
	always @(posedge clk)
		if (pv === 1'b1 && p_ready === 1'b1)
		begin
			got.push_back(pt);
			got_i.push_back(pi);
		end
	// ------
	// helpers
	// ------
	function automatic logic [POINT_W-1:0] al(input int v, input int sh);
		return POINT_W'(v << sh);
	endfunction
	task automatic chk(input string what, input logic [POINT_W-1:0] e, input logic [POINT_W-1:0] s);
		samples_checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_pts(input int n);
		for (int k = 0; k < 2000 && got.size() < n; k++)
			@(negedge clk);
	endtask
	task automatic drain;
		for (int k = 0; k < 300 && (dig_u.q.size() != 0 || pv === 1'b1); k++)
			@(negedge clk);
		dig_u.flush();
		repeat (2) @(negedge clk);
	endtask
	// four intervals of eight samples: first 3, max 7, min 0 above 16*k
	task automatic record(input logic [2:0] m, input int off, input int n);
		@(negedge clk);
		mode = m;
		got.delete();
		got_i.delete();
		for (int k = 0; k < 32; k++)
			dig_u.q.push_back(8'((k / 8) * 16 + ((k * 5 + 3) & 7) + off));
		@(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		wait_pts(n);
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_modes;
		chk("reset mode", 15'h0, 15'(mode_sel));
		chk("reset done", 15'h1, 15'(acq_done));
		record(3'h0, 0, 4);
		for (int k = 0; k < 4; k++)
			chk("first", al(16 * k + 3, 7), got[k]);
		drain();
		dig_u.slow = 1'b1;
		record(3'h1, 0, 4);
		for (int k = 0; k < 4; k++)
			chk("peak", al(16 * k + ((k % 2) ? 0 : 7), 7), got[k]);
		dig_u.slow = 1'b0;
		drain();
		tbase = 32'd200000;
		record(3'h2, 0, 4);
		chk("mean bits", 15'h9, 15'(res));
		for (int k = 0; k < 4; k++)
			chk("mean", al(32 * k + 7, 6), got[k]);
		drain();
		tbase = 32'd100000;
		record(3'h2, 0, 4);
		for (int k = 0; k < 4; k++)
			chk("mean base", al(16 * k + 3, 7), got[k]);
		drain();
		tbase = 32'd200000;
		span = 16'hFFFF;
		points = 7'h01;
		@(negedge clk);
		chk("mean cap", 15'hF, 15'(res));
		span = 16'h0020;
		points = 7'h04;
		mode = 3'h0;
		@(negedge clk);
		fast = 1'b1;
		for (int m = 2; m < 5; m++)
		begin
			mode = 3'(m);
			@(negedge clk);
			chk("refused mode", 15'h0, 15'(mode_sel));
		end
		fast = 1'b0;
	endtask
	task automatic t_fill;
		for (int c = 1; c < 5; c++)
		begin
			ch_on = 3'(c);
			need = 16'h0002;
			@(negedge clk);
			chk("interleave", (c == 1) ? 15'h2 : (c == 2) ? 15'h1 : 15'h0, 15'(ilv));
			chk("need fill", 15'(c > 2), 15'(nfill));
		end
		for (int s = 0; s < 2; s++)
		begin
			sinc = s[0];
			record(3'h0, 0, 3);
			chk("real flag", 15'h0, 15'(got_i[0]));
			chk("interp flag", 15'h1, 15'(got_i[1]));
			chk("interp", al(11, 7), got[1]);
			chk("real", al(19, 7), got[2]);
			drain();
		end
		record(3'h1, 0, 1);
		chk("peak as first", al(3, 7), got[0]);
		drain();
		et_en = 1'b1;
		record(3'h0, 0, 4);
		for (int k = 0; k < 4; k++)
			chk("no interp", 15'h0, 15'(got_i[k]));
		drain();
		et_en = 1'b0;
		ch_on = 3'h4;
		need = 16'h0001;
	endtask
	task automatic t_multi;
		acq_n = 16'h0002;
		for (int m = 3; m < 5; m++)
		begin
			record(3'(m), 0, 4);
			drain();
			chk("acq pending", 15'h0, 15'(acq_done));
			record(3'(m), 2, 4);
			for (int k = 0; k < 4; k++)
				if (m == 3)
					chk("envelope", al(16 * k + ((k % 2) ? 0 : 9), 7), got[k]);
				else
					chk("average", al(16 * k + 4, 7), got[k]);
			drain();
			chk("acq done", 15'h1, 15'(acq_done));
		end
		acq_n = 16'h0001;
	endtask
	task automatic t_fifo;
		span = 16'h0028;
		points = 7'h28;
		mode = 3'h0;
		p_ready = 1'b0;
		got.delete();
		for (int j = 0; j < 40; j++)
			dig_u.q.push_back(8'(j * 3));
		@(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (int k = 0; k < 300 && !(dig_u.q.size() < 9 && s_ready === 1'b0); k++)
			@(negedge clk);
		chk("full refuses", 15'h0, 15'(s_ready));
		chk("held", 15'h1, 15'(pv && dig_u.q.size() > 0 && got.size() == 0));
		for (int k = 0; k < 400 && got.size() < 40; k++)
		begin
			@(negedge clk);
			p_ready = k[0];
		end
		p_ready = 1'b1;
		for (int j = 0; j < 40; j++)
			chk("fifo order", al(j * 3, 7), got[j]);
		drain();
	endtask
	initial
	begin
		{rst, start, fast, et_en, sinc, p_ready} = 6'h21;
		mode = 3'h0;
		ch_on = 3'h4;
		span = 16'h0020;
		points = 7'h04;
		need = 16'h0001;
		tbase = 32'd50000;
		acq_n = 16'h0001;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_modes();
		t_fill();
		t_multi();
		t_fifo();
		report_and_stop();
	end
	// well above the several hundred cycles the scenarios need
	initial
	begin
		#400000;
		n_fail++;
		report_and_stop();
	end
endmodule
bind amd_decimator amd_decimator_asserts chk_u (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
	.I_MODE(I_MODE), .I_FAST_PERSIST(I_FAST_PERSIST), .I_CHANNELS_ON(I_CHANNELS_ON),
	.I_RECORD_SPAN(I_RECORD_SPAN), .I_RECORD_POINTS(I_RECORD_POINTS),
	.I_SAMPLES_NEEDED(I_SAMPLES_NEEDED), .I_TIMEBASE_PS_DIV(I_TIMEBASE_PS_DIV),
	.I_POINT_READY(I_POINT_READY), .O_POINT_VALID(O_POINT_VALID), .O_POINT(O_POINT),
	.O_MODE_ACTIVE(O_MODE_ACTIVE), .O_MODE_SELECTED(O_MODE_SELECTED),
	.O_RES_BITS(O_RES_BITS), .O_INTERLEAVE(O_INTERLEAVE), .O_NEED_FILL(O_NEED_FILL));
